// ==== smbcfg_pkg.sv ====
// Purpose: Shared constants for the two-wire bus configuration and timing block.
// Assumes: Special-function bus with byte data and 8-bit addresses.
// Notes:   Bit positions are listed once here and used by name in the design modules.
package smbcfg_pkg;
  localparam logic [7:0] ADDR_TIMING  = 8'h00_AC;
  localparam logic [7:0] ADDR_CONTROL = 8'h00_C0;
  localparam logic [7:0] ADDR_CONFIG  = 8'h00_C1;
  localparam logic [7:0] RESET_VALUE  = 8'h00_00;
  // Configuration register fields.
  localparam int CFG_ENABLE   = 7;
  localparam int CFG_INHIBIT  = 6;
  localparam int CFG_BUSY     = 5;
  localparam int CFG_SDA_HOLD_EXTEND_EN  = 4;
  localparam int CFG_TOE      = 3;
  localparam int CFG_FTE      = 2;
  localparam int CFG_SRC_HI   = 1;
  localparam int CFG_SRC_LO   = 0;
  // Timing and pin-control register fields.
  localparam int TC_SWAP      = 7;
  localparam int TC_WIN_HI    = 1;
  localparam int TC_WIN_LO    = 0;
  localparam logic [7:0] TC_WRITE_MASK = 8'h00_83;
  // Control and status register fields.
  localparam int CN_MASTER    = 7;
  localparam int CN_TRANSMIT_INDICATOR    = 6;
  localparam int CN_START     = 5;
  localparam int CN_STOP      = 4;
  localparam int CN_ACK_REQUEST     = 3;
  localparam int CN_ARBITRATION_LOST   = 2;
  localparam int CN_ACK       = 1;
  localparam int CN_DONE      = 0;
  // Least START hold, in system clocks, per window code.
  localparam logic [3:0] WIN_MIN_0 = 4'h0;
  localparam logic [3:0] WIN_MIN_1 = 4'h2;
  localparam logic [3:0] WIN_MIN_2 = 4'h4;
  localparam logic [3:0] WIN_MIN_3 = 4'h8;
  // Free-bus threshold, in bit-rate source periods (more than this).
  localparam logic [3:0] FREE_PERIODS = 4'hA;
  // Extended SDA hold after SCL falls.
  localparam int SYS_CLK_MHZ  = 125;
  localparam int EXT_HOLD_NS  = 80;
  localparam int EXT_HOLD_CYC = (EXT_HOLD_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage : smbcfg_pkg

// ==== smbcfg_det_if.sv ====
// Purpose: Carries synced pins, settings and bus events between controller and detector.
// Assumes: One system clock.
// Notes:   None.
`timescale 1ns/1ns
interface smbcfg_det_if;
  logic       sda;
  logic       scl;
  logic       enable;
  logic [1:0] window_sel;
  logic       free_en;
  logic       src_tick;
  logic       start_seen;
  logic       stop_seen;
  logic       bus_free;
  modport ctl (output sda, scl, enable, window_sel, free_en, src_tick,
               input start_seen, stop_seen, bus_free);
  modport det (input sda, scl, enable, window_sel, free_en, src_tick,
               output start_seen, stop_seen, bus_free);
endinterface : smbcfg_det_if

// ==== smbcfg_detect.sv ====
// Purpose: START, STOP and free-bus detection on already-synchronised pins.
// Assumes: Pins in the interface are two-flop synchronised by the caller.
// Notes:   Events are one-cycle pulses.
`timescale 1ns/1ns
module smbcfg_detect
  import smbcfg_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   reset_n_in,
  input  wire logic   ce_in,
  smbcfg_det_if.det   bus
);
  logic       sda_q;
  logic [3:0] hold_cnt;
  logic [3:0] free_cnt;
  logic       armed;
  logic       next_sda_q;
  logic [3:0] next_hold_cnt;
  logic [3:0] next_free_cnt;
  logic       next_armed;
  logic       next_start;
  logic       next_stop;
  logic       next_free;

  function automatic logic [3:0] win_min(input logic [1:0] sel);
    case (sel)
      2'h0:    win_min = WIN_MIN_0;
      2'h1:    win_min = WIN_MIN_1;
      2'h2:    win_min = WIN_MIN_2;
      default: win_min = WIN_MIN_3;
    endcase
  endfunction : win_min

  always_comb begin
    next_sda_q    = bus.sda;
    next_hold_cnt = hold_cnt;
    next_free_cnt = free_cnt;
    next_armed    = armed;
    next_start    = 1'b0;
    next_stop     = 1'b0;
    next_free     = 1'b0;
    if (!bus.enable) begin
      next_armed    = 1'b0;
      next_hold_cnt = 4'h0;
      next_free_cnt = 4'h0;
    end else begin
      // SDA falling while SCL high opens the START window.
      if (sda_q && !bus.sda && bus.scl) begin
        next_armed    = 1'b1;
        next_hold_cnt = 4'h0;
      end else if (armed && (bus.sda || !bus.scl)) begin
        next_armed = 1'b0;
        next_start = !bus.sda && (hold_cnt >= win_min(bus.window_sel));
      end else if (armed && hold_cnt != 4'hF) begin
        next_hold_cnt = hold_cnt + 4'h1;
      end
      next_stop = !sda_q && bus.sda && bus.scl;
      if (!(bus.sda && bus.scl) || !bus.free_en) begin
        next_free_cnt = 4'h0;
      end else if (bus.src_tick && free_cnt <= FREE_PERIODS) begin
        next_free_cnt = free_cnt + 4'h1;
        next_free     = (free_cnt == FREE_PERIODS);
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_q          <= 1'b1;
      hold_cnt       <= 4'h0;
      free_cnt       <= 4'h0;
      armed          <= 1'b0;
      bus.start_seen <= 1'b0;
      bus.stop_seen  <= 1'b0;
      bus.bus_free   <= 1'b0;
    end else if (ce_in) begin
      sda_q          <= next_sda_q;
      hold_cnt       <= next_hold_cnt;
      free_cnt       <= next_free_cnt;
      armed          <= next_armed;
      bus.start_seen <= next_start;
      bus.stop_seen  <= next_stop;
      bus.bus_free   <= next_free;
    end
  end
endmodule : smbcfg_detect

// ==== smbcfg_top.sv ====
// Purpose: Configuration, timing and pin control of a two-wire serial bus controller.
// Assumes: Transfer engine, timers and crossbar sit outside and use these ports.
// Notes:   Pins are open drain; an output enable low means the pin is pulled low.
`timescale 1ns/1ns

// Functional notes
// - Hold extension delays SDA changes after SCL.
// - Timeout enable: reload timer 3 while SCL high.
// - Split timer 3: reload only upper half.
// - Free after SCL, SDA high >10 periods.
// - Source select picks one of four overflows.
// - Swap bit reverses SDA/SCL port pin order.
// - START needs SDA-to-SCL fall window per code.
// - Control at 0xC0, bit set/clear addressable.
// - Byte done stalls engine; holds SCL low only while enabled.
// - Enable bit gates bus monitoring, except the timer 3 reload.
module smbcfg_top
  import smbcfg_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  // Special-function register port.
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic       sfr_bit_set_in,
  input  wire logic       sfr_bit_clr_in,
  input  wire logic [2:0] sfr_bit_in,
  output logic      [7:0] sfr_rdata_out,
  // Transfer engine side.
  input  wire logic       eng_sda_low_in,
  input  wire logic       eng_byte_done_in,
  input  wire logic       eng_master_in,
  input  wire logic       eng_transmit_indicator_in,
  input  wire logic       eng_ack_request_in,
  input  wire logic       eng_arb_lost_in,
  input  wire logic       eng_ack_in,
  input  wire logic       eng_ack_wr_in,
  input  wire logic       eng_stop_done_in,
  output logic            eng_stall_out,
  output logic            eng_start_out,
  output logic            eng_stop_out,
  // Timers.
  input  wire logic       t0_ovf_in,
  input  wire logic       t1_ovf_in,
  input  wire logic       t2_hi_ovf_in,
  input  wire logic       t2_lo_ovf_in,
  input  wire logic       t3_split_in,
  output logic            bit_tick_out,
  output logic            t3_reload_hi_out,
  output logic            t3_reload_lo_out,
  // Crossbar port pins, lower and higher numbered.
  input  wire logic       pin_lo_in,
  input  wire logic       pin_hi_in,
  output logic            pin_lo_out,
  output logic            pin_lo_oe_out,
  output logic            pin_hi_out,
  output logic            pin_hi_oe_out
);
  import smbcfg_pkg::*;

  smbcfg_det_if det_bus ();

  logic [7:0] cfg;
  logic [7:0] tc;
  logic [7:0] cn;
  logic [1:0] lo_sync;
  logic [1:0] hi_sync;
  logic       sda_drv_low;
  logic [3:0] ext_cnt;
  logic [7:0] next_cfg;
  logic [7:0] next_tc;
  logic [7:0] next_cn;
  logic [7:0] next_rdata;
  logic       next_sda_drv_low;
  logic [3:0] next_ext_cnt;
  logic       sda_s;
  logic       scl_s;
  logic       tick;

  // ****************************************
  // Pin synchronisers and crossbar order.
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lo_sync <= 2'h3;
      hi_sync <= 2'h3;
    end else if (ce_in) begin
      lo_sync <= {lo_sync[0], pin_lo_in};
      hi_sync <= {hi_sync[0], pin_hi_in};
    end
  end

  assign sda_s = tc[TC_SWAP] ? hi_sync[1] : lo_sync[1];
  assign scl_s = tc[TC_SWAP] ? lo_sync[1] : hi_sync[1];

  always_comb begin
    case (cfg[CFG_SRC_HI:CFG_SRC_LO])
      2'h0:    tick = t0_ovf_in;
      2'h1:    tick = t1_ovf_in;
      2'h2:    tick = t2_hi_ovf_in;
      default: tick = t2_lo_ovf_in;
    endcase
  end

  assign det_bus.sda        = sda_s;
  assign det_bus.scl        = scl_s;
  assign det_bus.enable     = cfg[CFG_ENABLE];
  assign det_bus.window_sel = tc[TC_WIN_HI:TC_WIN_LO];
  assign det_bus.free_en    = cfg[CFG_FTE];
  assign det_bus.src_tick   = tick;

  smbcfg_detect u_detect (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .bus        (det_bus.det)
  );

  // ****************************************
  // Register file.
  // ****************************************
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] c,
                                           input logic [7:0] t, input logic [7:0] n);
    case (addr)
      ADDR_CONFIG:  reg_read = c;
      ADDR_TIMING:  reg_read = t & TC_WRITE_MASK;
      ADDR_CONTROL: reg_read = n;
      default:      reg_read = RESET_VALUE;
    endcase
  endfunction : reg_read

  always_comb begin
    next_cfg   = cfg;
    next_tc    = tc;
    next_cn    = cn;
    next_rdata = sfr_rdata_out;
    if (sfr_rd_in) begin
      next_rdata = reg_read(sfr_addr_in, cfg, tc, cn);
    end
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        ADDR_CONFIG:  next_cfg = sfr_wdata_in;
        ADDR_TIMING:  next_tc = sfr_wdata_in & TC_WRITE_MASK;
        ADDR_CONTROL: next_cn = sfr_wdata_in;
        default:      next_cfg = cfg;
      endcase
    end else if (sfr_addr_in == ADDR_CONTROL && (sfr_bit_set_in || sfr_bit_clr_in)) begin
      next_cn[sfr_bit_in] = sfr_bit_set_in;
    end
    // Busy is hardware-owned; set by START, cleared by STOP, free timeout or the enable bit low.
    next_cfg[CFG_BUSY] = cfg[CFG_BUSY];
    if (det_bus.stop_seen || det_bus.bus_free || !cfg[CFG_ENABLE]) begin
      next_cfg[CFG_BUSY] = 1'b0;
    end
    if (det_bus.start_seen) begin
      next_cfg[CFG_BUSY] = 1'b1;
    end
    // Read-only status follows the engine.
    next_cn[CN_MASTER]  = eng_master_in;
    next_cn[CN_TRANSMIT_INDICATOR]  = eng_transmit_indicator_in;
    next_cn[CN_ACK_REQUEST]   = eng_ack_request_in;
    next_cn[CN_ARBITRATION_LOST] = eng_arb_lost_in;
    if (eng_ack_wr_in) begin
      next_cn[CN_ACK] = eng_ack_in;
    end
    if (eng_stop_done_in) begin
      next_cn[CN_STOP] = 1'b0;
    end
    // Hardware sets win over a software clear in the same cycle.
    if (det_bus.start_seen) begin
      next_cn[CN_START] = 1'b1;
    end
    if (det_bus.stop_seen && !eng_master_in) begin
      next_cn[CN_STOP] = 1'b1;
    end
    if (eng_byte_done_in) begin
      next_cn[CN_DONE] = 1'b1;
    end
  end

  // ****************************************
  // SDA hold extension.
  // ****************************************
  always_comb begin
    next_ext_cnt     = ext_cnt;
    next_sda_drv_low = eng_sda_low_in;
    if (scl_s) begin
      next_ext_cnt = 4'h0;
    end else if (ext_cnt != 4'(EXT_HOLD_CYC)) begin
      next_ext_cnt = ext_cnt + 4'h1;
    end
    if (cfg[CFG_SDA_HOLD_EXTEND_EN] && (scl_s || ext_cnt != 4'(EXT_HOLD_CYC))) begin
      next_sda_drv_low = sda_drv_low;
    end
    if (!cfg[CFG_ENABLE]) begin
      next_sda_drv_low = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg              <= RESET_VALUE;
      tc               <= RESET_VALUE;
      cn               <= RESET_VALUE;
      sfr_rdata_out    <= RESET_VALUE;
      sda_drv_low      <= 1'b0;
      ext_cnt          <= 4'h0;
      eng_stall_out    <= 1'b0;
      eng_start_out    <= 1'b0;
      eng_stop_out     <= 1'b0;
      bit_tick_out     <= 1'b0;
      t3_reload_hi_out <= 1'b0;
      t3_reload_lo_out <= 1'b0;
      pin_lo_out       <= 1'b0;
      pin_lo_oe_out    <= 1'b1;
      pin_hi_out       <= 1'b0;
      pin_hi_oe_out    <= 1'b1;
    end else if (ce_in) begin
      cfg              <= next_cfg;
      tc               <= next_tc;
      cn               <= next_cn;
      sfr_rdata_out    <= next_rdata;
      sda_drv_low      <= next_sda_drv_low;
      ext_cnt          <= next_ext_cnt;
      eng_stall_out    <= next_cn[CN_DONE];
      eng_start_out    <= next_cn[CN_START];
      eng_stop_out     <= next_cn[CN_STOP];
      bit_tick_out     <= tick && cfg[CFG_ENABLE];
      t3_reload_hi_out <= cfg[CFG_TOE] && scl_s;
      t3_reload_lo_out <= cfg[CFG_TOE] && scl_s && !t3_split_in;
      pin_lo_out       <= 1'b0;
      pin_hi_out       <= 1'b0;
      // SCL is held low while the byte-done flag stands and the enable bit is set.
      pin_lo_oe_out    <= !(tc[TC_SWAP] ? (next_cn[CN_DONE] && cfg[CFG_ENABLE])
                                        : next_sda_drv_low);
      pin_hi_oe_out    <= !(tc[TC_SWAP] ? next_sda_drv_low
                                        : (next_cn[CN_DONE] && cfg[CFG_ENABLE]));
    end
  end
endmodule : smbcfg_top

// ==== smbcfg_asserts.sv ====
// Purpose: Concurrent checks on the ports of the bus configuration block.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   Attached by the bind at the foot of this file.
`timescale 1ns/1ns
module smbcfg_asserts
  import smbcfg_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic       ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic       sfr_bit_set_in,
  input wire logic       sfr_bit_clr_in,
  input wire logic [2:0] sfr_bit_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       eng_byte_done_in,
  input wire logic       eng_stall_out,
  input wire logic       t0_ovf_in,
  input wire logic       t1_ovf_in,
  input wire logic       t2_hi_ovf_in,
  input wire logic       t2_lo_ovf_in,
  input wire logic       bit_tick_out,
  input wire logic       t3_reload_hi_out,
  input wire logic       t3_reload_lo_out
);
  // ****************************************
  // Port relations.
  // ****************************************
  logic rd_ok;
  assign rd_ok = ce_in && sfr_rd_in && !sfr_wr_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  tc_reserved_a: assert property (rd_ok && sfr_addr_in == ADDR_TIMING
    |=> sfr_rdata_out[6:2] == 5'h0_0) else $error("reserved timing bits not zero");
  tc_readback_a: assert property (ce_in && sfr_wr_in && sfr_addr_in == ADDR_TIMING ##2
    rd_ok && sfr_addr_in == ADDR_TIMING
    |=> sfr_rdata_out == ($past(sfr_wdata_in, 3) & TC_WRITE_MASK)) else $error("readback wrong");
  unmapped_read_a: assert property (rd_ok && sfr_addr_in != ADDR_TIMING
    && sfr_addr_in != ADDR_CONTROL && sfr_addr_in != ADDR_CONFIG
    |=> sfr_rdata_out == 8'h00_00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_ok |=> $stable(sfr_rdata_out))
    else $error("read data changed without a read");
  done_stall_a: assert property (ce_in && eng_byte_done_in |=> eng_stall_out)
    else $error("byte done did not stall");
  bit_set_a: assert property (ce_in && sfr_bit_set_in && !sfr_wr_in && sfr_bit_in == 3'h0
    && sfr_addr_in == ADDR_CONTROL |=> eng_stall_out) else $error("bit set of done flag lost");
  bit_clear_a: assert property (ce_in && sfr_bit_clr_in && !sfr_wr_in && sfr_bit_in == 3'h0
    && sfr_addr_in == ADDR_CONTROL && !sfr_bit_set_in && !eng_byte_done_in
    |=> !eng_stall_out) else $error("bit clear of done flag lost");
  split_reload_a: assert property (t3_reload_lo_out |-> t3_reload_hi_out)
    else $error("lower half reloaded alone");
  tick_source_a: assert property ($rose(bit_tick_out)
    |-> $past(t0_ovf_in || t1_ovf_in || t2_hi_ovf_in || t2_lo_ovf_in))
    else $error("bit tick without overflow");
endmodule : smbcfg_asserts

bind smbcfg_top smbcfg_asserts i_asserts (
  .clk_in, .reset_n_in, .ce_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_bit_set_in, .sfr_bit_clr_in, .sfr_bit_in, .sfr_rdata_out, .eng_byte_done_in,
  .eng_stall_out, .t0_ovf_in, .t1_ovf_in, .t2_hi_ovf_in, .t2_lo_ovf_in, .bit_tick_out,
  .t3_reload_hi_out, .t3_reload_lo_out);

// ==== smbcfg_peer.sv ====
// Purpose: Other two-wire bus parties, driving SDA and SCL as open-drain lines.
// Assumes: Pull-ups on both wires.
// Notes:   The caller chooses how long each line pattern is held.
`timescale 1ns/1ns
module smbcfg_peer (
  input  wire logic clk_in,
  input  wire logic swap_in,
  input  wire logic lo_oe_in,
  input  wire logic hi_oe_in,
  output logic      lo_level_out,
  output logic      hi_level_out
);
  // ****************************************
  // Wired lines.
  // ****************************************
  logic sda_rel = 1'b1;
  logic scl_rel = 1'b1;
  assign lo_level_out = lo_oe_in & (swap_in ? scl_rel : sda_rel);
  assign hi_level_out = hi_oe_in & (swap_in ? sda_rel : scl_rel);
  task automatic lines(input logic sda, input logic scl, input int hold);
    @(posedge clk_in);
    sda_rel <= sda;
    scl_rel <= scl;
    repeat (hold) @(posedge clk_in);
  endtask : lines
endmodule : smbcfg_peer

// ==== testbench.sv ====
// Purpose: Self-checking bench for the bus configuration and timing block.
// Assumes: Clock enable held high throughout.
// Notes:   Random register data and engine levels come from a fixed seed.
`timescale 1ns/1ns
module testbench;
  import smbcfg_pkg::*;
  // ****************************************
  // Signals and instances.
  // ****************************************
  logic       clk_in = 1'b0, reset_n_in = 1'b0, wr = 1'b0, rd = 1'b0, bset = 1'b0;
  logic       bclr = 1'b0, done = 1'b0, split = 1'b0, swap = 1'b0, sda_low = 1'b0;
  logic       stall, start, tick, rl_hi, rl_lo, lo_oe, hi_oe, lo_lvl, hi_lvl;
  logic [3:0] ovf = 4'h0, lvl = 4'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
  int         n_mismatch = 0, check_count = 0, cyc = 0;
  smbcfg_top i_dut (
    .clk_in, .reset_n_in, .ce_in(1'b1), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_bit_set_in(bset), .sfr_bit_clr_in(bclr),
    .sfr_bit_in(3'h0), .sfr_rdata_out(rdata), .eng_sda_low_in(sda_low),
    .eng_byte_done_in(done), .eng_master_in(lvl[3]), .eng_transmit_indicator_in(lvl[2]),
    .eng_ack_request_in(lvl[1]), .eng_arb_lost_in(lvl[0]), .eng_ack_in(1'b0),
    .eng_ack_wr_in(1'b0), .eng_stop_done_in(1'b0), .eng_stall_out(stall),
    .eng_start_out(start), .eng_stop_out(), .t0_ovf_in(ovf[0]), .t1_ovf_in(ovf[1]),
    .t2_hi_ovf_in(ovf[2]), .t2_lo_ovf_in(ovf[3]), .t3_split_in(split),
    .bit_tick_out(tick), .t3_reload_hi_out(rl_hi), .t3_reload_lo_out(rl_lo),
    .pin_lo_in(lo_lvl), .pin_hi_in(hi_lvl), .pin_lo_out(), .pin_lo_oe_out(lo_oe),
    .pin_hi_out(), .pin_hi_oe_out(hi_oe));
  smbcfg_peer i_peer (.clk_in, .swap_in(swap), .lo_oe_in(lo_oe), .hi_oe_in(hi_oe),
    .lo_level_out(lo_lvl), .hi_level_out(hi_lvl));
  always #4 clk_in = ~clk_in;
  // ****************************************
  // Helpers.
  // ****************************************
  function automatic logic [7:0] mirror(input logic [3:0] l);
    return {l[3:2], 2'b00, l[1:0], 2'b00};
  endfunction : mirror
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : put
  task automatic get(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    #1 got = rdata;
  endtask : get
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic strobe(input logic set);
    addr <= ADDR_CONTROL;
    bset <= set;
    bclr <= !set;
    @(posedge clk_in);
    bset <= 1'b0;
    bclr <= 1'b0;
    settle(1);
  endtask : strobe
  task automatic pulse(input int k);
    ovf[k] <= 1'b1;
    @(posedge clk_in);
    ovf <= 4'h0;
    #1 got = {7'h00, tick};
    @(posedge clk_in);
  endtask : pulse
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ****************************************
  // Scenarios.
  // ****************************************
  initial begin
    logic [7:0] d;
    void'($urandom(44));
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    get(ADDR_TIMING);
    check(got, RESET_VALUE);
    get(ADDR_CONTROL);
    check(got, RESET_VALUE);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'hFF : 8'($urandom);
      put(ADDR_TIMING, d);
      get(ADDR_TIMING);
      check(got, d & TC_WRITE_MASK);
    end
    get(8'h00_55);
    check(got, 8'h00_00);
    lvl <= 4'($urandom);
    settle(4);
    get(ADDR_CONTROL);
    check(got & 8'h00_CC, mirror(lvl));
    put(ADDR_TIMING, 8'h00_00);
    put(ADDR_CONFIG, 8'h00_88);
    for (int k = 0; k < 2; k++) begin
      split <= k[0];
      settle(5);
      check(rl_hi, 1'b1);
      check(rl_lo, !k[0]);
    end
    i_peer.lines(1'b1, 1'b0, 5);
    settle(1);
    check({rl_hi, rl_lo}, 2'b00);
    i_peer.lines(1'b1, 1'b1, 5);
    for (int k = 0; k < 2; k++) begin
      swap <= k[0];
      put(ADDR_TIMING, {k[0], 7'h00});
      put(ADDR_CONFIG, 8'h00_80);
      strobe(1'b1);
      check(stall, 1'b1);
      check({lo_oe, hi_oe}, k ? 2'b01 : 2'b10);
      put(ADDR_CONFIG, 8'h00_00);
      settle(1);
      check({lo_oe, hi_oe}, 2'b11);
      strobe(1'b0);
      check(stall, 1'b0);
    end
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
    settle(1);
    check(stall, 1'b1);
    strobe(1'b0);
    swap <= 1'b0;
    put(ADDR_TIMING, 8'h00_03);
    put(ADDR_CONFIG, 8'h00_80);
    for (int k = 0; k < 2; k++) begin
      i_peer.lines(1'b0, 1'b1, k ? 14 : 3);
      i_peer.lines(1'b0, 1'b0, 4);
      i_peer.lines(1'b1, 1'b0, 4);
      i_peer.lines(1'b1, 1'b1, 4);
      get(ADDR_CONTROL);
      check(got[CN_START], k[0]);
      check(start, k[0]);
    end
    put(ADDR_CONFIG, 8'h00_84);
    repeat (10) pulse(0);
    get(ADDR_CONFIG);
    check(got[CFG_BUSY], 1'b1);
    pulse(0);
    get(ADDR_CONFIG);
    check(got[CFG_BUSY], 1'b0);
    for (int k = 0; k < 16; k++) begin
      put(ADDR_CONFIG, 8'h80 | 8'(k >> 2));
      pulse(k % 4);
      check(got, 8'((k >> 2) == (k % 4)));
    end
    // Extended hold keeps SDA still until SCL has been low long enough.
    put(ADDR_CONFIG, 8'h00_90);
    sda_low <= 1'b1;
    settle(4);
    check(lo_oe, 1'b1);
    i_peer.lines(1'b1, 1'b0, 8);
    settle(1);
    check(lo_oe, 1'b1);
    settle(5);
    check(lo_oe, 1'b0);
    put(ADDR_CONFIG, 8'h00_00);
    sda_low <= 1'b0;
    settle(1);
    check(lo_oe, 1'b1);
    i_peer.lines(1'b1, 1'b1, 2);
    test_done();
  end
endmodule : testbench
